/* design/tbsr_consts.svh */
// constants for the trace buffer store and readout block
//
// Functional notes
// - detail mode records address and data of accesses
// - detail skips free and opcode fetch cycles
// - pure pc stores every executed opcode address
// - detail record uses address line then data line
// - detail record advances valid line counter twice
// - byte access: low data byte, high zero
// - word: lower address byte into byte1
// - line is 4+8+8 bits, data field2 zero
// - detail field2: size, direction, address 17:16
// - size flag 0 word, 1 byte
// - direction flag 0 write, 1 read
// - cof field2 bit3: 0 source, 1 destination
// - vector bit set forces destination bit set
// - cof and pure pc carry pc 17:16
// - readable only disarmed, source enabled, unsecured
// - arming locks buffer against reading
// - aligned word write while disarmed unlocks buffer
// - byte or misaligned reads return zero, pointer kept
// - fifo readout, count never decrements on read
// - read pointer starts at oldest entry
// - high half write restarts readout at oldest
// - first word fields 1,0; second word field2
// - read while armed: no pointer movement
// - begin trigger keeps capturing until 64 lines
// - reset keeps contents and valid line counter
// - source disabled: reads return zeroes
`ifndef TBSR_CONSTS_SVH
`define TBSR_CONSTS_SVH

// ==========================================================
// buffer geometry
`define TBSR_LINE_W      20
`define TBSR_DEPTH       64
`define TBSR_PTR_W       6
`define TBSR_CNT_W       7
`define TBSR_CNT_FULL    7'h40
`define TBSR_PTR_LAST    6'h3f

// ==========================================================
// field positions inside one line
`define TBSR_F2_HI       19
`define TBSR_F2_LO       16
`define TBSR_F1_HI       15
`define TBSR_F0_LO       0

`endif

/* design/tbsr_pkg.sv */
// types shared by the trace buffer store and readout modules
package tbsr_pkg;

    // ==========================================================
    // trace mode selection
    typedef enum logic [1:0] {
        TBSR_MODE_NORMAL,
        TBSR_MODE_LOOP,
        TBSR_MODE_DETAIL,
        TBSR_MODE_PURE_PC
    } tbsr_mode_e;

    // one stored buffer line
    typedef logic [19:0] tbsr_line_t;

endpackage

/* design/tbsr_line_if.sv */
// line stream with valid and ready between the block's own modules
`timescale 1ns/1ps
interface tbsr_line_if;
    import tbsr_pkg::*;
    logic       valid;
    logic       ready;
    tbsr_line_t line;

    modport source (output valid, output line, input ready);
    modport sink   (input valid, input line, output ready);
endinterface

/* design/tbsr_skid_buf.sv */
// two-entry line buffer between capture formatting and the trace memory
`timescale 1ns/1ps
module tbsr_skid_buf
    import tbsr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    tbsr_line_if.sink up,
    tbsr_line_if.source dn
);
    tbsr_line_t slot_reg [2];
    tbsr_line_t slot_next [2];
    logic       head_reg, head_next;
    logic [1:0] fill_reg, fill_next;
    logic       push, pop;

    // honest flags straight from the fill level
    assign up.ready = (fill_reg != 2'h2);
    assign dn.valid = (fill_reg != 2'h0);
    assign dn.line  = slot_reg[head_reg];
    assign push     = up.valid & up.ready;
    assign pop      = dn.valid & dn.ready;

    // slot written is the head when empty, else the one behind it
    always_comb
    begin
        slot_next = slot_reg;
        head_next = head_reg ^ pop;
        fill_next = fill_reg + {1'b0, push} - {1'b0, pop};
        if (push)
        begin
            slot_next[head_reg ^ fill_reg[0]] = up.line;
        end
    end

    always_ff @(posedge clk)
    begin
        slot_reg <= slot_next;
        if (rst)
        begin
            head_reg <= 1'b0;
            fill_reg <= 2'h0;
        end
        else
        begin
            head_reg <= head_next;
            fill_reg <= fill_next;
        end
    end
endmodule

/* design/tbsr_line_ram.sv */
// trace line memory, one write port and one asynchronous read port
`timescale 1ns/1ps
`include "tbsr_consts.svh"
module tbsr_line_ram
    import tbsr_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   wr_en,
    input  wire logic [`TBSR_PTR_W-1:0] wr_addr,
    input  wire tbsr_line_t             wr_line,
    input  wire logic [`TBSR_PTR_W-1:0] rd_addr,
    output tbsr_line_t                  rd_line
);
    tbsr_line_t mem [`TBSR_DEPTH];

    // no reset on purpose: lines survive a system reset
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_line;
        end
    end

    assign rd_line = mem[rd_addr];
endmodule

/* design/tbsr_trace_top.sv */
// trace capture, line formatting, locking and word readout of the debug trace unit
`timescale 1ns/1ps
`include "tbsr_consts.svh"
module tbsr_trace_top
    import tbsr_pkg::*;
(
    input  wire logic                    CLOCK,
    input  wire logic                    SYS_RST,
    // trace configuration
    input  wire tbsr_pkg::tbsr_mode_e    TRACE_MODE,
    input  wire logic                    TRACE_SOURCE_ENABLE,
    input  wire logic                    ALIGN_BEGIN,
    input  wire logic                    SECURED,
    // arm control and trigger from the sequencer
    input  wire logic                    ARM_SET,
    input  wire logic                    ARM_CLEAR,
    input  wire logic                    TRIGGER,
    // cpu bus cycle for detail mode
    input  wire logic                    BUS_VALID,
    input  wire logic                    BUS_FREE,
    input  wire logic                    BUS_OPFETCH,
    input  wire logic [17:0]             BUS_ADDR,
    input  wire logic                    BUS_BYTE,
    input  wire logic                    BUS_READ,
    input  wire logic [7:0]              BUS_LOW_ADDR_BYTE,
    input  wire logic [7:0]              BUS_HIGH_ADDR_BYTE,
    // program counter events
    input  wire logic                    OPCODE_EXEC,
    input  wire logic                    COF_VALID,
    input  wire logic                    COF_DEST,
    input  wire logic                    COF_VECTOR,
    input  wire logic [17:0]             PC_ADDR,
    // trace buffer port access
    input  wire logic                    TB_RD,
    input  wire logic                    TB_WR,
    input  wire logic                    TB_WR_HIGH,
    input  wire logic                    TB_ALIGNED_WORD,
    output logic      [15:0]             TB_RDATA,
    output logic                         TB_RVALID,
    // status
    output logic      [`TBSR_CNT_W-1:0]  VALID_LINE_COUNT,
    output logic                         ARMED,
    output logic                         LOCKED,
    output logic                         OVERFLOW,
    output logic                         CAP_READY
);
    import tbsr_pkg::*;

    // ==========================================================
    // state registers
    logic                   armed_reg, armed_next;
    logic                   trig_reg, trig_next;
    logic                   locked_reg, locked_next;
    logic                   cap_ready_reg, cap_ready_next;
    logic                   pend_reg, pend_next;
    tbsr_line_t             pend_line_reg, pend_line_next;
    logic [`TBSR_CNT_W-1:0] push_cnt_reg, push_cnt_next;
    logic [`TBSR_CNT_W-1:0] cnt_reg, cnt_next;
    logic [`TBSR_PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
    logic                   ovf_reg, ovf_next;
    logic [`TBSR_PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
    logic                   rd_half_reg, rd_half_next;
    logic [15:0]            rdata_reg, rdata_next;
    logic                   rvalid_reg, rvalid_next;

    // ==========================================================
    // internal nets
    logic                   capturing;
    logic                   detail_hit;
    logic                   pc_hit;
    logic                   cof_mode;
    tbsr_line_t             addr_line;
    tbsr_line_t             data_line;
    tbsr_line_t             pc_line;
    logic                   fmt_take;
    logic                   mem_wr;
    logic [`TBSR_PTR_W-1:0] oldest;
    logic                   rd_ok;
    logic                   rd_take;
    logic                   wr_ok;
    tbsr_line_t             ram_line;

    tbsr_line_if fmt_s ();
    tbsr_line_if mem_s ();

    // ==========================================================
    // buffer and memory
    tbsr_skid_buf u_buf (
        .clk (CLOCK),
        .rst (SYS_RST),
        .up  (fmt_s.sink),
        .dn  (mem_s.source)
    );

    tbsr_line_ram u_ram (
        .clk     (CLOCK),
        .wr_en   (mem_wr),
        .wr_addr (wr_ptr_reg),
        .wr_line (mem_s.line),
        .rd_addr (rd_ptr_reg),
        .rd_line (ram_line)
    );

    // ==========================================================
    // capture qualification
    // begin alignment stores nothing before the trigger and stops at a full buffer
    assign capturing = armed_reg & TRACE_SOURCE_ENABLE
                     & (~ALIGN_BEGIN | (trig_reg & (push_cnt_reg < `TBSR_CNT_FULL)));
    assign cof_mode  = (TRACE_MODE == TBSR_MODE_NORMAL) | (TRACE_MODE == TBSR_MODE_LOOP);

    // free and opcode fetch cycles carry nothing worth tracing
    assign detail_hit = (TRACE_MODE == TBSR_MODE_DETAIL)
                      & BUS_VALID & ~BUS_FREE & ~BUS_OPFETCH;
    assign pc_hit     = ((TRACE_MODE == TBSR_MODE_PURE_PC) & OPCODE_EXEC)
                      | (cof_mode & COF_VALID);

    // ==========================================================
    // line formats
    // address line: size flag, direction flag, address 17:16, then middle and low bytes
    assign addr_line = {BUS_BYTE,
                        BUS_READ,
                        BUS_ADDR[17:16],
                        BUS_ADDR[15:0]};

    // data line: field2 zero; a byte sits low, a word puts the lower address high
    assign data_line = BUS_BYTE
                     ? {4'h0, 8'h00, BUS_LOW_ADDR_BYTE}
                     : {4'h0, BUS_LOW_ADDR_BYTE, BUS_HIGH_ADDR_BYTE};

    // same line for normal, loop and pure pc; flags only mean something in cof modes
    assign pc_line = {cof_mode & (COF_DEST | COF_VECTOR),
                      cof_mode & COF_VECTOR,
                      PC_ADDR[17:16],
                      PC_ADDR[15:0]};

    // ==========================================================
    // formatter towards the buffer
    // a pending data line goes first; a new hit while it waits is dropped
    assign fmt_s.valid = pend_reg | (capturing & (detail_hit | pc_hit));
    assign fmt_s.line  = pend_reg ? pend_line_reg
                       : (detail_hit ? addr_line : pc_line);
    assign fmt_take    = fmt_s.valid & fmt_s.ready;

    // ==========================================================
    // memory write side
    // the drain stalls for a readout access so the buffer really fills
    assign rd_ok       = ~armed_reg & TRACE_SOURCE_ENABLE & ~SECURED
                       & ~locked_reg & TB_ALIGNED_WORD;
    assign rd_take     = TB_RD & rd_ok;
    assign mem_s.ready = ~rd_take;
    assign mem_wr      = mem_s.valid & mem_s.ready;
    assign oldest      = ovf_reg ? wr_ptr_reg : {`TBSR_PTR_W{1'b0}};
    assign wr_ok       = TB_WR & TB_ALIGNED_WORD & ~armed_reg & ~ARM_SET;

    // ==========================================================
    // arm, trigger and lock state
    always_comb
    begin
        armed_next  = armed_reg;
        trig_next   = trig_reg;
        locked_next = locked_reg;
        if (ARM_SET)
        begin
            armed_next  = 1'b1;
            trig_next   = 1'b0;
            locked_next = 1'b1;
        end
        else
        begin
            if (ARM_CLEAR)
            begin
                armed_next = 1'b0;
            end
            else if (armed_reg & TRIGGER)
            begin
                // end alignment stops at the trigger, begin alignment starts there
                if (ALIGN_BEGIN)
                begin
                    trig_next = 1'b1;
                end
                else
                begin
                    armed_next = 1'b0;
                end
            end
            // full check stands apart so a late trigger cannot mask it
            if (armed_reg & ALIGN_BEGIN & mem_wr
                & (cnt_reg == `TBSR_CNT_FULL - 7'h01))
            begin
                armed_next = 1'b0;
            end
            if (wr_ok)
            begin
                locked_next = 1'b0;
            end
        end
    end

    // ==========================================================
    // formatter state
    always_comb
    begin
        pend_next      = pend_reg;
        pend_line_next = pend_line_reg;
        push_cnt_next  = push_cnt_reg;
        if (fmt_take)
        begin
            push_cnt_next = push_cnt_reg + 7'h01;
        end
        if (pend_reg)
        begin
            if (fmt_s.ready)
            begin
                pend_next = 1'b0;
            end
        end
        else if (fmt_take & detail_hit)
        begin
            // address line went in, the data line follows next
            pend_next      = 1'b1;
            pend_line_next = data_line;
        end
        if (ARM_SET)
        begin
            push_cnt_next = {`TBSR_CNT_W{1'b0}};
            pend_next     = 1'b0;
        end
        cap_ready_next = ~pend_next & fmt_s.ready;
    end

    // ==========================================================
    // write pointer, valid line counter and overflow
    always_comb
    begin
        wr_ptr_next = wr_ptr_reg;
        cnt_next    = cnt_reg;
        ovf_next    = ovf_reg;
        if (mem_wr)
        begin
            // each line counts, so a detail record advances the count twice
            wr_ptr_next = wr_ptr_reg + 6'h01;
            if (cnt_reg != `TBSR_CNT_FULL)
            begin
                cnt_next = cnt_reg + 7'h01;
            end
            if (wr_ptr_reg == `TBSR_PTR_LAST)
            begin
                ovf_next = 1'b1;
            end
        end
        if (ARM_SET)
        begin
            wr_ptr_next = {`TBSR_PTR_W{1'b0}};
            cnt_next    = {`TBSR_CNT_W{1'b0}};
            ovf_next    = 1'b0;
        end
    end

    // ==========================================================
    // readout pointer and read data
    always_comb
    begin
        rd_ptr_next  = rd_ptr_reg;
        rd_half_next = rd_half_reg;
        rdata_next   = 16'h0000;
        rvalid_next  = TB_RD;
        if (wr_ok & (TB_WR_HIGH | locked_reg))
        begin
            // unlocking and every high half write restart at the oldest line
            rd_ptr_next  = oldest;
            rd_half_next = 1'b0;
        end
        else if (rd_take)
        begin
            // low word first, then field2; the count is left alone
            rdata_next = rd_half_reg
                       ? {12'h000, ram_line[`TBSR_F2_HI:`TBSR_F2_LO]}
                       : ram_line[`TBSR_F1_HI:`TBSR_F0_LO];
            rd_half_next = ~rd_half_reg;
            if (rd_half_reg)
            begin
                rd_ptr_next = rd_ptr_reg + 6'h01;
            end
        end
        // armed, locked, secured or misaligned reads leave zero and a still pointer
        if (~rd_take)
        begin
            rdata_next = 16'h0000;
        end
    end

    // ==========================================================
    // registers with reset
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            armed_reg     <= 1'b0;
            trig_reg      <= 1'b0;
            locked_reg    <= 1'b1;
            cap_ready_reg <= 1'b0;
            pend_reg      <= 1'b0;
            pend_line_reg <= '0;
            push_cnt_reg  <= {`TBSR_CNT_W{1'b0}};
            rd_half_reg   <= 1'b0;
            rdata_reg     <= 16'h0000;
            rvalid_reg    <= 1'b0;
        end
        else
        begin
            armed_reg     <= armed_next;
            trig_reg      <= trig_next;
            locked_reg    <= locked_next;
            cap_ready_reg <= cap_ready_next;
            pend_reg      <= pend_next;
            pend_line_reg <= pend_line_next;
            push_cnt_reg  <= push_cnt_next;
            rd_half_reg   <= rd_half_next;
            rdata_reg     <= rdata_next;
            rvalid_reg    <= rvalid_next;
        end
    end

    // ==========================================================
    // registers kept across system reset
    // trace session survives reset; only arming starts a fresh one
    always_ff @(posedge CLOCK)
    begin
        wr_ptr_reg <= wr_ptr_next;
        cnt_reg    <= cnt_next;
        ovf_reg    <= ovf_next;
        rd_ptr_reg <= rd_ptr_next;
    end

    // ==========================================================
    // outputs, all from flip-flops
    assign TB_RDATA         = rdata_reg;
    assign TB_RVALID        = rvalid_reg;
    assign VALID_LINE_COUNT = cnt_reg;
    assign ARMED            = armed_reg;
    assign LOCKED           = locked_reg;
    assign OVERFLOW         = ovf_reg;
    assign CAP_READY        = cap_ready_reg;
endmodule

/* tb/tbsr_trace_monitor.sv */
// port checks for the trace buffer store and readout top
`timescale 1ns/1ps
`include "tbsr_consts.svh"
module tbsr_trace_monitor
(
    input  wire logic                   CLOCK,
    input  wire logic                   SYS_RST,
    input  wire logic                   TRACE_SOURCE_ENABLE,
    input  wire logic                   ALIGN_BEGIN,
    input  wire logic                   SECURED,
    input  wire logic                   ARM_SET,
    input  wire logic                   TB_RD,
    input  wire logic                   TB_ALIGNED_WORD,
    input  wire logic [15:0]            TB_RDATA,
    input  wire logic                   TB_RVALID,
    input  wire logic [`TBSR_CNT_W-1:0] VALID_LINE_COUNT,
    input  wire logic                   ARMED,
    input  wire logic                   LOCKED
);
    // ==========================================================
    // helper: count is unknown until the first arm, so wait for it
    logic seen_reg = 1'b0;
    logic seen_next;
    always_comb seen_next = seen_reg | ARM_SET;
    always_ff @(posedge CLOCK) seen_reg <= seen_next;

    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    // ==========================================================
    // readout and count relations
    AST_RD_ANSWER: assert property (TB_RD |=> TB_RVALID)
        else $error("read not answered next cycle");
    AST_NO_SPURIOUS: assert property (!TB_RD |=> !TB_RVALID)
        else $error("answer without read");
    AST_REFUSED_ZERO: assert property (TB_RD && (ARMED || LOCKED || SECURED
        || !TRACE_SOURCE_ENABLE || !TB_ALIGNED_WORD) |=> TB_RDATA == 16'h0000)
        else $error("refused read gave data");
    AST_ARM_LOCKS: assert property (ARM_SET |=> ARMED && LOCKED)
        else $error("arm did not lock");
    AST_ARM_CLEARS: assert property (ARM_SET |=> VALID_LINE_COUNT == 7'h00)
        else $error("arm did not start a fresh session");
    AST_COUNT_KEEPS: assert property (seen_reg && !ARM_SET && !$past(ARM_SET)
        |=> VALID_LINE_COUNT >= $past(VALID_LINE_COUNT))
        else $error("line count decreased");
    AST_COUNT_MAX: assert property (seen_reg && !$past(ARM_SET)
        |-> VALID_LINE_COUNT <= 7'h40)
        else $error("line count above buffer depth");
    AST_BEGIN_STOP: assert property ((ALIGN_BEGIN && ARMED && !ARM_SET
        && VALID_LINE_COUNT == 7'h3f) ##1 (VALID_LINE_COUNT == 7'h40) |-> !ARMED)
        else $error("begin trace stayed armed when full");
endmodule

bind tbsr_trace_top tbsr_trace_monitor i_mon
(
    .CLOCK               (CLOCK),
    .SYS_RST             (SYS_RST),
    .TRACE_SOURCE_ENABLE (TRACE_SOURCE_ENABLE),
    .ALIGN_BEGIN         (ALIGN_BEGIN),
    .SECURED             (SECURED),
    .ARM_SET             (ARM_SET),
    .TB_RD               (TB_RD),
    .TB_ALIGNED_WORD     (TB_ALIGNED_WORD),
    .TB_RDATA            (TB_RDATA),
    .TB_RVALID           (TB_RVALID),
    .VALID_LINE_COUNT    (VALID_LINE_COUNT),
    .ARMED               (ARMED),
    .LOCKED              (LOCKED)
);

/* tb/tbsr_cpu_model.sv */
// cpu side model: bus cycles and program counter events
`timescale 1ns/1ps
module tbsr_cpu_model
(
    input  wire logic   clk,
    input  wire logic   cap_ready,
    output logic        bus_valid = 1'b0,
    output logic        bus_free = 1'b0,
    output logic        bus_opfetch = 1'b0,
    output logic [17:0] bus_addr = 18'h0_0000,
    output logic        bus_byte = 1'b0,
    output logic        bus_read = 1'b0,
    output logic [7:0]  lo_byte = 8'h00,
    output logic [7:0]  hi_byte = 8'h00,
    output logic        op_exec = 1'b0,
    output logic        cof_valid = 1'b0,
    output logic        cof_dest = 1'b0,
    output logic        cof_vector = 1'b0,
    output logic [17:0] pc = 18'h0_0000
);
    // ==========================================================
    // hold until taken; bounded so a dead formatter cannot hang us
    task automatic take();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!cap_ready && n < 40);
    endtask

    // kind 0 plain access, 1 free cycle, 2 opcode fetch
    task automatic bus(input logic [17:0] a, input logic b, input logic r,
                       input logic [7:0] l, input logic [7:0] h, input logic [1:0] kind);
        @(posedge clk);
        bus_valid <= 1'b1;
        bus_free <= kind[0];
        bus_opfetch <= kind[1];
        {bus_addr, bus_byte, bus_read, lo_byte, hi_byte} <= {a, b, r, l, h};
        if (kind == 2'd0)
            take();
        else
            @(posedge clk);
        // released address and data lines show their inverse, never the last value
        bus_valid <= 1'b0;
        {bus_addr, lo_byte, hi_byte} <= ~{a, l, h};
    endtask

    // cof high: change of flow record, low: executed opcode
    task automatic pcev(input logic cof, input logic [17:0] p, input logic d, input logic v);
        @(posedge clk);
        op_exec <= !cof;
        cof_valid <= cof;
        {pc, cof_dest, cof_vector} <= {p, d, v};
        take();
        {op_exec, cof_valid} <= 2'b00;
        pc <= ~p;
    endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the trace buffer store and readout block
`timescale 1ns/1ps
module tb;
    import tbsr_pkg::*;
    logic        CLOCK = 1'b0;
    logic        SYS_RST = 1'b1;
    tbsr_mode_e  TRACE_MODE = TBSR_MODE_DETAIL;
    logic        TRACE_SOURCE_ENABLE = 1'b1, ALIGN_BEGIN = 1'b0, SECURED = 1'b0;
    logic        ARM_SET = 1'b0, ARM_CLEAR = 1'b0, TRIGGER = 1'b0;
    logic        TB_RD = 1'b0, TB_WR = 1'b0, TB_WR_HIGH = 1'b0, TB_ALIGNED_WORD = 1'b1;
    logic        BUS_VALID, BUS_FREE, BUS_OPFETCH, BUS_BYTE, BUS_READ;
    logic [17:0] BUS_ADDR, PC_ADDR;
    logic [7:0]  BUS_LOW_ADDR_BYTE, BUS_HIGH_ADDR_BYTE;
    logic        OPCODE_EXEC, COF_VALID, COF_DEST, COF_VECTOR;
    logic [15:0] TB_RDATA;
    logic [6:0]  VALID_LINE_COUNT;
    logic        TB_RVALID, ARMED, LOCKED, OVERFLOW, CAP_READY;
    int          n_fail = 0;
    int          checks = 0;

    tbsr_trace_top i_dut (.*);
    tbsr_cpu_model i_cpu (.clk(CLOCK), .cap_ready(CAP_READY), .bus_valid(BUS_VALID),
        .bus_free(BUS_FREE), .bus_opfetch(BUS_OPFETCH), .bus_addr(BUS_ADDR),
        .bus_byte(BUS_BYTE), .bus_read(BUS_READ), .lo_byte(BUS_LOW_ADDR_BYTE),
        .hi_byte(BUS_HIGH_ADDR_BYTE), .op_exec(OPCODE_EXEC), .cof_valid(COF_VALID),
        .cof_dest(COF_DEST), .cof_vector(COF_VECTOR), .pc(PC_ADDR));

    initial
    begin
        forever #2 CLOCK = ~CLOCK;
    end

    // ==========================================================
    // shared helpers
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // k: 0 arm, 1 trigger, 2 disarm
    task automatic ctl(input int k);
        @(posedge CLOCK);
        ARM_SET <= (k == 0);
        TRIGGER <= (k == 1);
        ARM_CLEAR <= (k == 2);
        @(posedge CLOCK);
        {ARM_SET, TRIGGER, ARM_CLEAR} <= 3'b000;
    endtask

    task automatic wr(input logic high);
        @(posedge CLOCK);
        TB_WR <= 1'b1;
        TB_WR_HIGH <= high;
        @(posedge CLOCK);
        TB_WR <= 1'b0;
    endtask

    // answer is registered, so look one cycle after the request
    task automatic rd(input logic al, input logic [15:0] exp);
        @(posedge CLOCK);
        TB_RD <= 1'b1;
        TB_ALIGNED_WORD <= al;
        @(posedge CLOCK);
        TB_RD <= 1'b0;
        TB_ALIGNED_WORD <= 1'b1;
        #1;
        chk("answer", 16'h0001, {15'h0, TB_RVALID});
        chk("read data", exp, TB_RDATA);
    endtask

    task automatic rline(input logic [3:0] f2, input logic [15:0] f10);
        rd(1'b1, f10);
        rd(1'b1, {12'h000, f2});
    endtask

    task automatic count_is(input logic [6:0] exp);
        repeat (4) @(posedge CLOCK);
        #1;
        chk("line count", {9'h0, exp}, {9'h0, VALID_LINE_COUNT});
    endtask

    // ==========================================================
    // scenarios
    task automatic sc_detail();
        @(posedge CLOCK);
        TRACE_MODE <= TBSR_MODE_DETAIL;
        ctl(0);
        #1;
        chk("ready armed locked", 16'h0007, {13'h0, CAP_READY, ARMED, LOCKED});
        i_cpu.bus(18'h2_1234, 1'b0, 1'b1, 8'hab, 8'hcd, 2'd0);
        i_cpu.bus(18'h3_0000, 1'b0, 1'b1, 8'h11, 8'h22, 2'd1);
        i_cpu.bus(18'h3_0002, 1'b0, 1'b1, 8'h33, 8'h44, 2'd2);
        i_cpu.bus(18'h1_0056, 1'b1, 1'b0, 8'h5a, 8'hee, 2'd0);
        rd(1'b1, 16'h0000);
        wr(1'b1);
        ctl(1);
        count_is(7'h04);
        rd(1'b1, 16'h0000);
        wr(1'b1);
        rline(4'h6, 16'h1234);
        rd(1'b0, 16'h0000);
        rline(4'h0, 16'habcd);
        rline(4'h9, 16'h0056);
        rline(4'h0, 16'h005a);
        wr(1'b1);
        rline(4'h6, 16'h1234);
    endtask

    // contents survive a reset; refused reads leave the pointer alone
    task automatic sc_reset_keep();
        @(posedge CLOCK);
        SYS_RST <= 1'b1;
        repeat (2) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        count_is(7'h04);
        wr(1'b1);
        rline(4'h6, 16'h1234);
        @(posedge CLOCK) TRACE_SOURCE_ENABLE <= 1'b0;
        rd(1'b1, 16'h0000);
        @(posedge CLOCK) TRACE_SOURCE_ENABLE <= 1'b1;
        SECURED <= 1'b1;
        rd(1'b1, 16'h0000);
        @(posedge CLOCK) SECURED <= 1'b0;
        rd(1'b1, 16'habcd);
    endtask

    task automatic sc_pure_begin();
        @(posedge CLOCK);
        TRACE_MODE <= TBSR_MODE_PURE_PC;
        ALIGN_BEGIN <= 1'b1;
        ctl(0);
        i_cpu.pcev(1'b0, 18'h2_0000, 1'b1, 1'b1);
        ctl(1);
        for (int i = 0; i < 66; i++)
            i_cpu.pcev(1'b0, {2'b10, 16'h0100 + 16'(i)}, 1'b1, 1'b1);
        count_is(7'h40);
        chk("armed", 16'h0000, {15'h0, ARMED});
        wr(1'b1);
        rline(4'h2, 16'h0100);
    endtask

    // overflow: oldest surviving record is the third one sent
    task automatic sc_cof(input tbsr_mode_e m);
        @(posedge CLOCK);
        TRACE_MODE <= m;
        ALIGN_BEGIN <= 1'b0;
        ctl(0);
        for (int i = 0; i < 66; i++)
            i_cpu.pcev(1'b1, {2'b01, 16'h0200 + 16'(i)}, i[1], i[0]);
        ctl(2);
        count_is(7'h40);
        chk("overflow", 16'h0001, {15'h0, OVERFLOW});
        wr(1'b0);
        for (int i = 2; i < 6; i++)
            rline({i[1] | i[0], i[0], 2'b01}, 16'h0200 + 16'(i));
    endtask

    initial
    begin
        repeat (6) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        sc_detail();
        sc_reset_keep();
        sc_pure_begin();
        sc_cof(TBSR_MODE_NORMAL);
        sc_cof(TBSR_MODE_LOOP);
        conclude();
    end

    // whole run needs well under a thousand cycles
    initial
    begin
        #80000;
        n_fail++;
        conclude();
    end
endmodule
